// File: inc/scan_port_pkg.sv
/*
  Shared constants and types for the scan test port and emulation pin logic.
  Assumes one system clock that oversamples the test clock by at least four.
*/
package scan_port_pkg;

  // instruction register
  localparam int unsigned IR_LEN        = 4;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;  // fixed 01 pattern in the low bits
  localparam logic [3:0]  INS_BYPASS    = 4'hF;
  localparam logic [3:0]  INS_EMU_CTRL  = 4'h2;
  localparam logic [3:0]  IR_RESET      = INS_BYPASS;

  // emulation control data register: {emu1_oe, emu1_val, emulation_pin_zero_oe, emulation_pin_zero_val}
  localparam int unsigned EMU_LEN       = 4;
  localparam int unsigned EMULATION_PIN_ZERO_VAL_BIT  = 0;
  localparam int unsigned EMULATION_PIN_ZERO_OE_BIT   = 1;
  localparam int unsigned EMU1_VAL_BIT  = 2;
  localparam int unsigned EMU1_OE_BIT   = 3;
  localparam logic [3:0]  EMU_RESET     = 4'h0;

  // synchroniser stages on every pin input
  localparam int unsigned SYNC_STAGES   = 2;

  // test access controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_type;

endpackage

// File: core/pin_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous levels; only the second stage may be read.
*/
`timescale 1ns/1ps
module pin_sync
  import scan_port_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_type;

  sync_type sync_r;
  sync_type sync_nxt;

  // refused while elaborating: an empty group has nothing to synchronise
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs WIDTH of at least one");
  end

  // first stage feeds only the second stage
  always_comb begin
    sync_nxt.meta = i_async;
    sync_nxt.held = sync_r.meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r.held;

endmodule

// File: core/scan_port.sv
/*
  Boundary-scan test access port with two multiplexed emulation pins.
  The test clock is oversampled by the system clock; rising and falling test
  clock edges become one-cycle enables. Assumes I_REF_CLK runs at least four
  times faster than the test clock and that pad pullups and pulldowns are
  resolved outside, but for the mode-select and data-in pullups, resolved here from the *_DRIVEN inputs telling whether a pin is driven.
*/
`timescale 1ns/1ps

module scan_port
  import scan_port_pkg::*;
#(
  parameter int unsigned IR_WIDTH = IR_LEN
) (
  // system clock and reset
  input  wire logic I_REF_CLK,
  input  wire logic I_RST_N,
  // scan port pins
  input  wire logic I_TCK,
  input  wire logic I_TMS,
  input  wire logic I_TMS_DRIVEN,
  input  wire logic I_TDI,
  input  wire logic I_TDI_DRIVEN,
  input  wire logic I_TRST,
  output logic      O_TDO,
  output logic      O_TDO_OE,
  // emulation pin zero
  input  wire logic I_EMULATION_PIN_ZERO,
  output logic      O_EMULATION_PIN_ZERO,
  output logic      O_EMULATION_PIN_ZERO_OE,
  // emulation pin one with outputs-off
  input  wire logic I_EMULATION_PIN_ONE_OUTPUTS_OFF,
  output logic      O_EMULATION_PIN_ONE_OUTPUTS_OFF,
  output logic      O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE,
  // device-wide status
  output logic      O_SCAN_MODE,
  output logic      O_OUTPUTS_OFF
);

  localparam int unsigned NPINS = 8;

  typedef struct packed {
    tap_state_type         tap;
    logic [IR_WIDTH-1:0]   ir_shift;
    logic [IR_WIDTH-1:0]   ir;
    logic [EMU_LEN-1:0]    dr_emu;
    logic [EMU_LEN-1:0]    emu_ctrl;
    logic                  bypass;
    logic                  tck_prev;
    logic                  tdo;
    logic                  tdo_oe;
    logic                  emulation_pin_zero;
    logic                  emulation_pin_zero_oe;
    logic                  emu1;
    logic                  emu1_oe;
    logic                  scan;
    logic                  off;
  } state_type;

  state_type   st_r;
  state_type   st_nxt;
  logic [NPINS-1:0] pins_s;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst;
  logic        emulation_pin_zero_in;
  logic        emu1_in;

  // other widths would need their own capture pattern and opcodes
  if (IR_WIDTH != IR_LEN) begin : g_bad_ir_width
    $error("scan_port supports only the packaged instruction width");
  end

  // every pin input passes two flops before any logic sees it
  pin_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_async ({I_TCK, I_TMS, I_TMS_DRIVEN, I_TDI, I_TDI_DRIVEN, I_TRST, I_EMULATION_PIN_ZERO, I_EMULATION_PIN_ONE_OUTPUTS_OFF}),
    .o_sync  (pins_s)
  );

  // an open mode-select or data-in pin reads as its pullup level
  assign tck     = pins_s[7];
  assign tms     = pins_s[5] ? pins_s[6] : 1'b1;
  assign tdi     = pins_s[3] ? pins_s[4] : 1'b1;
  assign trst    = pins_s[2];
  assign emulation_pin_zero_in = pins_s[1];
  assign emu1_in = pins_s[0];

  // standard controller successor for a sampled mode-select value
  function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
    unique case (s)
      TEST_LOGIC_RESET: tap_next = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE:    tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR:        tap_next = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR:       tap_next = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         tap_next = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         tap_next = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         tap_next = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         tap_next = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR:        tap_next = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       tap_next = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         tap_next = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         tap_next = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         tap_next = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         tap_next = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        tap_next = m ? SELECT_DR : RUN_TEST_IDLE;
    endcase
  endfunction

  // whole next state: edge detect, controller, registers, pin drive
  always_comb begin
    logic rise;
    logic fall;
    logic emu_sel;
    rise    = 1'b0;
    fall    = 1'b0;
    emu_sel = 1'b0;
    st_nxt  = st_r;
    st_nxt.tck_prev = tck;
    rise    = tck & ~st_r.tck_prev;
    fall    = ~tck & st_r.tck_prev;
    emu_sel = (st_r.ir == INS_EMU_CTRL);
    st_nxt.scan = trst;
    if (!trst) begin
      // functional mode: scan inputs ignored, controller held in reset
      st_nxt.tap      = TEST_LOGIC_RESET;
      st_nxt.ir       = IR_RESET;
      st_nxt.emu_ctrl = EMU_RESET;
      st_nxt.tdo_oe   = 1'b0;
      st_nxt.emulation_pin_zero_oe  = 1'b0;
      st_nxt.emu1_oe  = 1'b0;
      // outputs-off needs pin zero high and pin one low
      st_nxt.off      = emulation_pin_zero_in & ~emu1_in;
    end else begin
      st_nxt.off = 1'b0;
      if (rise) begin
        unique case (st_r.tap)
          TEST_LOGIC_RESET: begin
            st_nxt.ir       = IR_RESET;
            st_nxt.emu_ctrl = EMU_RESET;
          end
          CAPTURE_DR: begin
            // value bits report the synchronised pin levels, whoever drives them
            st_nxt.dr_emu = {st_r.emu_ctrl[EMU1_OE_BIT], emu1_in,
                             st_r.emu_ctrl[EMULATION_PIN_ZERO_OE_BIT], emulation_pin_zero_in};
            st_nxt.bypass = 1'b0;
          end
          SHIFT_DR: begin
            if (emu_sel) begin
              st_nxt.dr_emu = {tdi, st_r.dr_emu[EMU_LEN-1:1]};
            end else begin
              st_nxt.bypass = tdi;
            end
          end
          UPDATE_DR: begin
            if (emu_sel) begin
              st_nxt.emu_ctrl = st_r.dr_emu;
            end
          end
          CAPTURE_IR: begin
            st_nxt.ir_shift = IR_CAPTURE;
          end
          SHIFT_IR: begin
            st_nxt.ir_shift = {tdi, st_r.ir_shift[IR_WIDTH-1:1]};
          end
          UPDATE_IR: begin
            st_nxt.ir = st_r.ir_shift;
          end
          default: begin
          end
        endcase
        st_nxt.tap = tap_next(st_r.tap, tms);
      end
      // data out moves half a test clock after the shift, on the fall
      if (fall) begin
        st_nxt.tdo_oe = (st_r.tap == SHIFT_DR) || (st_r.tap == SHIFT_IR);
        if (st_r.tap == SHIFT_IR) begin
          st_nxt.tdo = st_r.ir_shift[0];
        end else if (emu_sel) begin
          st_nxt.tdo = st_r.dr_emu[0];
        end else begin
          st_nxt.tdo = st_r.bypass;
        end
      end
      // emulation pins are two-way lines steered by the control register
      st_nxt.emulation_pin_zero    = st_r.emu_ctrl[EMULATION_PIN_ZERO_VAL_BIT];
      st_nxt.emulation_pin_zero_oe = st_r.emu_ctrl[EMULATION_PIN_ZERO_OE_BIT];
      st_nxt.emu1    = st_r.emu_ctrl[EMU1_VAL_BIT];
      st_nxt.emu1_oe = st_r.emu_ctrl[EMU1_OE_BIT];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      st_r          <= '0;
      st_r.tap      <= TEST_LOGIC_RESET;
      st_r.ir       <= IR_RESET;
      st_r.ir_shift <= IR_CAPTURE;
      st_r.emu_ctrl <= EMU_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // all outputs come straight from the state register
  assign O_TDO         = st_r.tdo;
  assign O_TDO_OE      = st_r.tdo_oe;
  assign O_EMULATION_PIN_ZERO        = st_r.emulation_pin_zero;
  assign O_EMULATION_PIN_ZERO_OE     = st_r.emulation_pin_zero_oe;
  assign O_EMULATION_PIN_ONE_OUTPUTS_OFF    = st_r.emu1;
  assign O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE = st_r.emu1_oe;
  assign O_SCAN_MODE   = st_r.scan;
  assign O_OUTPUTS_OFF = st_r.off;

endmodule

// File: testbench/scan_port_monitor.sv
/*
  Port-level checker for the scan test port and emulation pins.
  Assumes it is bound to scan_port and sees only that module's ports.
*/
`timescale 1ns/1ps
module scan_port_monitor (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // pins and status watched
  input wire logic I_TCK,
  input wire logic I_TRST,
  input wire logic I_EMULATION_PIN_ZERO,
  input wire logic I_EMULATION_PIN_ONE_OUTPUTS_OFF,
  input wire logic O_TDO,
  input wire logic O_TDO_OE,
  input wire logic O_EMULATION_PIN_ZERO_OE,
  input wire logic O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE,
  input wire logic O_SCAN_MODE,
  input wire logic O_OUTPUTS_OFF
);
  // six stable cycles leave room for the pin synchronisers
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  a_off_armed: assert property ((!I_TRST && I_EMULATION_PIN_ZERO && !I_EMULATION_PIN_ONE_OUTPUTS_OFF)[*6] |-> O_OUTPUTS_OFF)
    else $error("outputs off not raised");
  a_off_blocked: assert property ((I_TRST || !I_EMULATION_PIN_ZERO || I_EMULATION_PIN_ONE_OUTPUTS_OFF)[*6] |-> !O_OUTPUTS_OFF)
    else $error("outputs off raised without arming");
  a_scan_on: assert property (I_TRST[*6] |-> O_SCAN_MODE)
    else $error("scan mode missing");
  a_scan_ignored: assert property ((!I_TRST)[*6] |-> !O_SCAN_MODE && !O_TDO_OE)
    else $error("scan active in functional mode");
  // output changes must trail a low test clock seen through the synchroniser
  a_tdo_fall: assert property (O_SCAN_MODE && $past(O_SCAN_MODE) && $changed(O_TDO) |-> !$past(I_TCK, 2))
    else $error("data out changed away from a falling test clock");
  a_oe_fall: assert property (O_SCAN_MODE && $past(O_SCAN_MODE) && $changed(O_TDO_OE) |-> !$past(I_TCK, 2))
    else $error("data out enable changed away from a falling test clock");
  a_emulation_pin_zero_dir: assert property ((!O_SCAN_MODE)[*3] |-> !O_EMULATION_PIN_ZERO_OE)
    else $error("pin zero driven outside scan mode");
  a_emu1_dir: assert property ((!O_SCAN_MODE)[*3] |-> !O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE)
    else $error("pin one driven outside scan mode");
endmodule

// File: testbench/scan_host.sv
/*
  Behavioural scan controller driving the test clock, mode select and data in.
  Assumes the bench calls bit_io; the test clock rests low between calls.
*/
`timescale 1ns/1ps
module scan_host (
  // scan pins driven
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tms_drv,
  output logic      o_tdi,
  output logic      o_tdi_drv,
  // data out seen
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tms_drv = 1'b0;
    o_tdi = 1'b1;
    o_tdi_drv = 1'b0;
  end
  // one even test clock period; tdo sampled late in the high phase, where it stands
  task automatic bit_io(input logic drv, input logic tms, input logic tdi, output logic tdo);
    o_tms_drv = drv;
    o_tdi_drv = drv;
    o_tms = drv ? tms : 1'b1;  // released pins sit at the pullup level
    o_tdi = drv ? tdi : 1'b1;
    #100 o_tck = 1'b1;
    #99 tdo = i_tdo;
    #1 o_tck = 1'b0;
  endtask
endmodule

// File: testbench/tb_top.sv
/*
  Self-checking bench for scan_port with a behavioural scan controller.
  Assumes the 40 MHz clock; random values come from a fixed-seed xorshift.
*/
`timescale 1ns/1ps
module tb_top;
  import scan_port_pkg::*;
  logic clk, rst_n, trst, e0, e1, t;
  logic [31:0] rnd;
  logic [3:0] d, ctl, nv;
  int err_total, check_count, i;
  wire tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, emulation_pin_zero_o, emulation_pin_zero_oe, emu1_o, emu1_oe;
  wire scan_mode, outs_off;
  // two-way pins: device drive wins, else the emulator level; a floating tdo reads inverted
  wire emulation_pin_zero = emulation_pin_zero_oe ? emulation_pin_zero_o : e0;
  wire emu1 = emu1_oe ? emu1_o : e1;
  scan_port scan_port_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_TCK(tck), .I_TMS(tms),
    .I_TMS_DRIVEN(tms_drv), .I_TDI(tdi), .I_TDI_DRIVEN(tdi_drv), .I_TRST(trst), .O_TDO(tdo),
    .O_TDO_OE(tdo_oe), .I_EMULATION_PIN_ZERO(emulation_pin_zero), .O_EMULATION_PIN_ZERO(emulation_pin_zero_o), .O_EMULATION_PIN_ZERO_OE(emulation_pin_zero_oe), .I_EMULATION_PIN_ONE_OUTPUTS_OFF(emu1),
    .O_EMULATION_PIN_ONE_OUTPUTS_OFF(emu1_o), .O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE(emu1_oe), .O_SCAN_MODE(scan_mode),
    .O_OUTPUTS_OFF(outs_off));
  scan_host scan_host_inst (.o_tck(tck), .o_tms(tms), .o_tms_drv(tms_drv), .o_tdi(tdi),
    .o_tdi_drv(tdi_drv), .i_tdo(tdo_oe ? tdo : ~tdo));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // capture of the emulation register sees pin levels where the device is not driving
  function automatic logic [3:0] cap_exp(input logic [3:0] c, input logic p0, input logic p1);
    return {c[3], c[3] ? c[2] : p1, c[1], c[1] ? c[0] : p0};
  endfunction
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // idle to idle through one capture, four shifts and an update
  task automatic scan(input logic ir, input logic [3:0] din, output logic [3:0] dout);
    scan_host_inst.bit_io(1'b1, 1'b1, 1'b0, t);
    if (ir) scan_host_inst.bit_io(1'b1, 1'b1, 1'b0, t);
    scan_host_inst.bit_io(1'b1, 1'b0, 1'b0, t);
    scan_host_inst.bit_io(1'b1, 1'b0, 1'b0, t);
    for (int k = 0; k < 4; k++) scan_host_inst.bit_io(1'b1, k == 3, din[k], dout[k]);
    scan_host_inst.bit_io(1'b1, 1'b1, 1'b0, t);
    scan_host_inst.bit_io(1'b1, 1'b0, 1'b0, t);
  endtask
  task automatic summarize;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog well beyond the expected 24.5 us of traffic
  initial begin
    #200000;
    err_total++;
    summarize;
  end
  initial begin
    rst_n = 1'b0;
    trst = 1'b0;
    e0 = 1'b1;
    e1 = 1'b1;
    rnd = 32'hD2F5;
    err_total = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("tdo_oe", 4'h0, {3'h0, tdo_oe});
    // functional mode: scan traffic ignored, outputs-off follows the emulation pins
    for (i = 0; i < 20; i++) begin
      rnd = xs(rnd);
      e0 = rnd[0] | (i == 0);  // armed corner first, then random
      e1 = rnd[1] & (i != 0);
      scan_host_inst.bit_io(1'b1, rnd[2], rnd[3], t);
      chk("outputs_off", {3'h0, e0 & ~e1}, {3'h0, outs_off});
      chk("scan_idle", 4'h0, {2'h0, scan_mode, tdo_oe});
    end
    trst = 1'b1;
    repeat (8) @(negedge clk);
    chk("scan_mode", 4'h2, {2'h0, scan_mode, outs_off});
    scan_host_inst.bit_io(1'b1, 1'b0, 1'b0, t);
    scan(1'b1, INS_EMU_CTRL, d);
    chk("ir_capture", IR_CAPTURE, d);
    chk("tdo_rest", 4'h0, {3'h0, tdo_oe});
    ctl = EMU_RESET;
    // emulation register: all-ones corner first, then random drive patterns
    for (i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      e0 = rnd[0];
      e1 = rnd[1];
      nv = (i == 0) ? 4'hF : rnd[5:2];
      scan(1'b0, nv, d);
      chk("emu_capture", cap_exp(ctl, e0, e1), d);
      ctl = nv;
      chk("emu_drive", ctl, {emu1_oe, emu1_o, emulation_pin_zero_oe, emulation_pin_zero_o});
    end
    // five released mode-select bits reach reset, which restores bypass
    repeat (5) scan_host_inst.bit_io(1'b0, 1'b0, 1'b0, t);
    scan_host_inst.bit_io(1'b1, 1'b0, 1'b0, t);
    rnd = xs(rnd);
    nv = rnd[3:0];
    scan(1'b0, nv, d);
    chk("bypass", {nv[2:0], 1'b0}, d);
    // drive both emulation pins low, then leave scan with outputs-off armed
    e0 = 1'b1;
    e1 = 1'b0;
    scan(1'b1, INS_EMU_CTRL, d);
    chk("ir_capture", IR_CAPTURE, d);
    scan(1'b0, 4'hA, d);
    chk("emu_capture", cap_exp(EMU_RESET, 1'b1, 1'b0), d);
    chk("emu_drive", 4'hA, {emu1_oe, emu1_o, emulation_pin_zero_oe, emulation_pin_zero_o});
    trst = 1'b0;
    repeat (8) @(negedge clk);
    chk("emu_release", 4'h4, {emu1_oe, outs_off, emulation_pin_zero_oe, scan_mode});
    summarize;
  end
endmodule
bind scan_port scan_port_monitor scan_port_monitor_inst (.I_REF_CLK(I_REF_CLK),
  .I_RST_N(I_RST_N), .I_TCK(I_TCK), .I_TRST(I_TRST), .I_EMULATION_PIN_ZERO(I_EMULATION_PIN_ZERO),
  .I_EMULATION_PIN_ONE_OUTPUTS_OFF(I_EMULATION_PIN_ONE_OUTPUTS_OFF), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_EMULATION_PIN_ZERO_OE(O_EMULATION_PIN_ZERO_OE),
  .O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE(O_EMULATION_PIN_ONE_OUTPUTS_OFF_OE), .O_SCAN_MODE(O_SCAN_MODE), .O_OUTPUTS_OFF(O_OUTPUTS_OFF));
